//--- verilog/pic_pkg.sv
package pic_pkg;

  localparam int NUM_SRC = 24;
  localparam int REG_W = 8;
  localparam int NUM_EV = 2;

  // register indexes; byte address is four times the index
  localparam logic [11:0] IDX_REQ0 = 12'h0fc0;
  localparam logic [11:0] IDX_PRIH0 = 12'h0fc1;
  localparam logic [11:0] IDX_PRIL0 = 12'h0fc2;
  localparam logic [11:0] IDX_REQ1 = 12'h0fc3;
  localparam logic [11:0] IDX_PRIH1 = 12'h0fc4;
  localparam logic [11:0] IDX_PRIL1 = 12'h0fc5;
  localparam logic [11:0] IDX_REQ2 = 12'h0fc6;
  localparam logic [11:0] IDX_PRIH2 = 12'h0fc7;
  localparam logic [11:0] IDX_PRIL2 = 12'h0fc8;
  localparam logic [11:0] IDX_CTRL = 12'h0fcf;
  localparam logic [11:0] IDX_ISTAT = 12'h0fd0;
  localparam logic [11:0] IDX_IMASK = 12'h0fd1;

  localparam logic [7:0] RST_REQ = 8'h00;
  localparam logic [7:0] RST_PRIO = 8'h00;
  localparam logic RST_GATE = 1'b0;
  localparam logic [1:0] RST_EV = 2'h0;

  // control register gate bit; event bits in status and mask
  localparam int GATE_BIT = 7;
  localparam int EV_ACK = 0;
  localparam int EV_OVR = 1;

  localparam logic [15:0] VEC_WDT = 16'h0004;
  localparam logic [15:0] VEC_TRAP = 16'h0006;
  localparam logic [15:0] VEC_BASE = 16'h0008;
  localparam logic [15:0] VEC_STEP = 16'h0002;

  typedef enum logic [1:0] {KIND_NONE, KIND_WDT, KIND_TRAP, KIND_PROG}
    pic_kind_t;

endpackage

//--- verilog/pic_arbiter.sv
`timescale 1ns/1ps
module pic_arbiter import pic_pkg::*;
#(
  parameter int N = NUM_SRC
)
(
  input wire logic [N-1:0] pend,
  input wire logic [N-1:0] enh,
  input wire logic [N-1:0] enl,
  input wire logic wdt_pend,
  input wire logic trap_pend,
  input wire logic gate,
  output pic_kind_t win_kind,
  output logic [4:0] win_idx
);

  always_comb
  begin
    int idx;
    logic found;
    idx = 0;
    found = 1'b0;
    win_kind = KIND_NONE;
    win_idx = 5'h00;
    // level 3 first, then 2, then 1; inside a level, fixed rank
    for (int lv = 3; lv >= 1; lv--) // R3
    begin
      for (int k = 0; k < N; k++) // R4 R15
      begin
        idx = (k / 8) * 8 + 7 - (k % 8);
        if (!found && gate && pend[idx] // R12
            && {enh[idx], enl[idx]} == 2'(lv)) // R16
        begin
          found = 1'b1;
          win_kind = KIND_PROG;
          win_idx = 5'(idx);
        end
      end
    end
    // fixed sources outrank every level
    if (trap_pend) // R5
    begin
      win_kind = KIND_TRAP;
      win_idx = 5'h00;
    end
    if (wdt_pend) // R5 R14
    begin
      win_kind = KIND_WDT;
      win_idx = 5'h00;
    end
  end

endmodule

//--- verilog/pic_top.sv
// Behaviour
// R1: gate set by enable instruction, return-from-service, or writing 1.
// R2: gate cleared by disable, acknowledge, writing 0, reset, traps.
// R3: level 3 beats level 2 beats level 1.
// R4: same level resolved by fixed per-source rank.
// R5: reset, enabled watchdog and illegal trap outrank all levels.
// R6: sources pulse one cycle; pulse captured into sticky pending bit.
// R7: acknowledge clears serviced pending bit until next pulse.
// R8: writing 0 to a pending bit clears the request.
// R9: writing 1 to a pending bit raises a request.
// R10: software should use atomic read-modify-write on pending bits.
// R11: pulses set pending bits whatever the gate state.
// R12: requests reach the core only while the gate is set; watchdog and trap requests reach it with the gate clear.
// R13: first request register at index FC0, reset 0, fixed bit layout.
// R14: watchdog is handled outside the programmable registers.
// R15: fixed order reset, watchdog, trap, then sources in vector order.
// R16: enable pair 00 off, 01 level 1, 10 level 2, 11 level 3.
// R17: vector is a 16-bit even program address.
// R18: a pulse in the clearing cycle wins, bit stays set.
`timescale 1ns/1ps
module pic_top import pic_pkg::*;
#(
  parameter int ADDR_W = 14
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_SRC-1:0] src_pulse,
  input wire logic wdt_pulse,
  input wire logic wdt_int_en,
  input wire logic illegal_trap,
  input wire logic enable_irq_instruction,
  input wire logic mask_all_instruction,
  input wire logic return_from_service,
  input wire logic trap_instruction,
  input wire logic cpu_ack,
  output logic cpu_irq_req,
  output logic [15:0] cpu_vector,
  output logic irq
);

  typedef struct packed {
    logic [NUM_SRC-1:0] pend;
    logic [NUM_SRC-1:0] enh;
    logic [NUM_SRC-1:0] enl;
    logic gate;
    logic wdt_pend;
    logic trap_pend;
    logic [NUM_EV-1:0] ist;
    logic [NUM_EV-1:0] imask;
    logic req;
    logic [15:0] vec;
    pic_kind_t kind;
    logic [4:0] idx;
    logic [31:0] rdata;
    logic slverr;
  } pic_state_t;

  pic_state_t state_r;
  pic_state_t state_nxt;
  pic_kind_t win_kind;
  logic [4:0] win_idx;

  ////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic mapped(input logic [11:0] ri);
    case (ri)
      IDX_REQ0, IDX_PRIH0, IDX_PRIL0,
      IDX_REQ1, IDX_PRIH1, IDX_PRIL1,
      IDX_REQ2, IDX_PRIH2, IDX_PRIL2,
      IDX_CTRL, IDX_ISTAT, IDX_IMASK: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction

  // register bit idx -> program address of its vector
  function automatic logic [15:0] vec_of(input logic [4:0] idx);
    logic [4:0] rank;
    rank = {idx[4:3], ~idx[2:0]};
    vec_of = VEC_BASE + VEC_STEP * {11'h000, rank}; // R17 R15
  endfunction

  function automatic logic [7:0] rd_mux(input logic [11:0] ri,
                                        input pic_state_t s);
    case (ri)
      IDX_REQ0: rd_mux = s.pend[7:0]; // R13
      IDX_PRIH0: rd_mux = s.enh[7:0];
      IDX_PRIL0: rd_mux = s.enl[7:0];
      IDX_REQ1: rd_mux = s.pend[15:8];
      IDX_PRIH1: rd_mux = s.enh[15:8];
      IDX_PRIL1: rd_mux = s.enl[15:8];
      IDX_REQ2: rd_mux = s.pend[23:16];
      IDX_PRIH2: rd_mux = s.enh[23:16];
      IDX_PRIL2: rd_mux = s.enl[23:16];
      IDX_CTRL: rd_mux = {s.gate, 7'h00};
      IDX_ISTAT: rd_mux = {6'h00, s.ist};
      IDX_IMASK: rd_mux = {6'h00, s.imask};
      default: rd_mux = 8'h00;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // arbitration

  pic_arbiter #(
    .N(NUM_SRC)
  ) u_arb (
    .pend(state_r.pend),
    .enh(state_r.enh),
    .enl(state_r.enl),
    .wdt_pend(state_r.wdt_pend),
    .trap_pend(state_r.trap_pend),
    .gate(state_r.gate),
    .win_kind(win_kind),
    .win_idx(win_idx)
  );

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    logic [11:0] ri;
    logic setup;
    logic wr;
    logic [NUM_SRC-1:0] pulse;
    logic [7:0] wd;
    ri = paddr[ADDR_W-1:2];
    setup = psel && !penable;
    wr = psel && penable && pwrite && !state_r.slverr;
    pulse = src_pulse;
    wd = pwdata[7:0];
    state_nxt = state_r;

    // bus: read data and error taken in setup, write in access
    if (setup)
    begin
      state_nxt.slverr = !mapped(ri) || (paddr[1:0] != 2'b00);
      state_nxt.rdata = {24'h000000, rd_mux(ri, state_r)};
    end

    // acknowledge clears the presented source and the gate
    if (cpu_ack && state_r.req)
    begin
      case (state_r.kind)
        KIND_PROG: state_nxt.pend[state_r.idx] = 1'b0; // R7
        KIND_WDT: state_nxt.wdt_pend = 1'b0;
        KIND_TRAP: state_nxt.trap_pend = 1'b0;
        default: state_nxt.pend = state_nxt.pend;
      endcase
      state_nxt.gate = 1'b0; // R2
    end

    if (enable_irq_instruction || return_from_service)
      state_nxt.gate = 1'b1; // R1
    if (mask_all_instruction || trap_instruction || illegal_trap)
      state_nxt.gate = 1'b0; // R2

    if (wr)
    begin
      case (ri)
        IDX_REQ0: state_nxt.pend[7:0] = wd; // R8 R9
        IDX_REQ1: state_nxt.pend[15:8] = wd; // R8 R9
        IDX_REQ2: state_nxt.pend[23:16] = wd; // R8 R9
        IDX_PRIH0: state_nxt.enh[7:0] = wd;
        IDX_PRIL0: state_nxt.enl[7:0] = wd;
        IDX_PRIH1: state_nxt.enh[15:8] = wd;
        IDX_PRIL1: state_nxt.enl[15:8] = wd;
        IDX_PRIH2: state_nxt.enh[23:16] = wd;
        IDX_PRIL2: state_nxt.enl[23:16] = wd;
        IDX_CTRL: state_nxt.gate = wd[GATE_BIT]; // R1 R2
        IDX_ISTAT: state_nxt.ist = state_r.ist & ~wd[NUM_EV-1:0];
        IDX_IMASK: state_nxt.imask = wd[NUM_EV-1:0];
        default: state_nxt.slverr = state_r.slverr;
      endcase
    end

    // pulses last so they win over any clear
    state_nxt.pend = state_nxt.pend | pulse; // R6 R11 R18
    if (wdt_pulse && wdt_int_en)
      state_nxt.wdt_pend = 1'b1; // R14 R18
    if (illegal_trap)
      state_nxt.trap_pend = 1'b1; // R18

    // events: set wins over write-one-clear
    if (cpu_ack && state_r.req)
      state_nxt.ist[EV_ACK] = 1'b1;
    if (|(pulse & state_r.pend))
      state_nxt.ist[EV_OVR] = 1'b1;

    // winner presented one cycle later, dropped on acknowledge
    state_nxt.req = (win_kind != KIND_NONE) && !cpu_ack; // R12
    state_nxt.kind = win_kind;
    state_nxt.idx = win_idx;
    case (win_kind)
      KIND_WDT: state_nxt.vec = VEC_WDT; // R5
      KIND_TRAP: state_nxt.vec = VEC_TRAP; // R5
      KIND_PROG: state_nxt.vec = vec_of(win_idx); // R17
      default: state_nxt.vec = 16'h0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r.pend <= {RST_REQ, RST_REQ, RST_REQ}; // R13
      state_r.enh <= {RST_PRIO, RST_PRIO, RST_PRIO};
      state_r.enl <= {RST_PRIO, RST_PRIO, RST_PRIO};
      state_r.gate <= RST_GATE; // R2
      state_r.wdt_pend <= 1'b0;
      state_r.trap_pend <= 1'b0;
      state_r.ist <= RST_EV;
      state_r.imask <= RST_EV;
      state_r.req <= 1'b0;
      state_r.vec <= 16'h0000;
      state_r.kind <= KIND_NONE;
      state_r.idx <= 5'h00;
      state_r.rdata <= 32'h0000_0000;
      state_r.slverr <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign pready = psel && penable;
  assign pslverr = psel && penable && state_r.slverr;
  assign prdata = state_r.rdata;
  assign cpu_irq_req = state_r.req;
  assign cpu_vector = state_r.vec;
  assign irq = |(state_r.ist & state_r.imask);

endmodule

//--- tb/pic_asserts.sv
`timescale 1ns/1ps
module pic_asserts import pic_pkg::*;
#(
  parameter int ADDR_W = 14
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic wdt_pulse,
  input wire logic wdt_int_en,
  input wire logic illegal_trap,
  input wire logic enable_irq_instruction,
  input wire logic return_from_service,
  input wire logic cpu_ack,
  input wire logic cpu_irq_req,
  input wire logic [15:0] cpu_vector
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // nothing that could reopen the gate or raise a fixed source
  sequence quiet;
    !enable_irq_instruction && !return_from_service && !illegal_trap
      && !wdt_pulse && !(psel && pwrite);
  endsequence
  sequence prog_ack;
    cpu_ack && cpu_irq_req && cpu_vector >= VEC_BASE;
  endsequence
  rdy_follow_a: assert property (pready == (psel && penable))
    else $error("pready not tied to access phase");
  err_phase_a: assert property (pslverr |-> psel && penable)
    else $error("error outside access phase");
  bad_align_a: assert property (psel && penable && paddr[1:0] != 2'b00
    |-> pslverr) else $error("unaligned access not refused");
  rd_width_a: assert property (prdata[31:8] == 24'h00_0000)
    else $error("read data above bit 7");
  vec_legal_a: assert property (cpu_irq_req |-> !cpu_vector[0]
    && cpu_vector >= VEC_WDT && cpu_vector <= 16'h0036)
    else $error("vector out of table");
  ack_drop_a: assert property (cpu_ack && cpu_irq_req |=> !cpu_irq_req)
    else $error("request held after ack");
  gate_shut_a: assert property (quiet ##1 (prog_ack and quiet)
    ##1 quiet[*2] |=> !cpu_irq_req) else $error("gate open after ack");
  wdt_first_a: assert property ((wdt_pulse && wdt_int_en && !cpu_ack)
    ##1 !cpu_ack |=> cpu_irq_req && cpu_vector == VEC_WDT)
    else $error("watchdog not presented first");
endmodule
bind pic_top pic_asserts #(.ADDR_W(ADDR_W)) chk_u (.*);

//--- tb/pic_cpu_model.sv
`timescale 1ns/1ps
module pic_cpu_model
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cpu_irq_req,
  input wire logic [15:0] cpu_vector,
  input wire logic [3:0] wait_cyc,
  output logic cpu_ack,
  output logic [15:0] taken_vec
);
  logic [3:0] cnt_r;
  // acks a presented request after wait_cyc cycles, records its vector
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_r <= 4'h0;
      cpu_ack <= 1'b0;
      taken_vec <= 16'h0000;
    end
    else if (cpu_ack)
    begin
      cpu_ack <= 1'b0;
      cnt_r <= 4'h0;
      taken_vec <= cpu_vector;
    end
    else if (cpu_irq_req)
    begin
      cpu_ack <= (cnt_r == wait_cyc);
      cnt_r <= cnt_r + 4'h1;
    end
  end
endmodule

//--- tb/tb_top.sv
`timescale 1ns/1ps
module tb_top import pic_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
  logic wdt_int_en = 0, pready, pslverr, cpu_ack, cpu_irq_req, irq;
  logic [13:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic [23:0] src_pulse = '0;
  logic [15:0] cpu_vector, tv;
  logic [5:0] ev = '0;
  logic [3:0] wt = '0;
  logic [7:0] rd;
  int n_errors = 0, n_checks = 0, cyc = 0;
  initial forever #4 pclk = ~pclk;
  pic_top dut_u (.*, .enable_irq_instruction(ev[0]),
    .mask_all_instruction(ev[1]), .return_from_service(ev[2]),
    .trap_instruction(ev[3]), .illegal_trap(ev[4]), .wdt_pulse(ev[5]));
  pic_cpu_model cpu_u (.*, .wait_cyc(wt), .taken_vec(tv));
  ////////////////////////////////////////////////////////////////////
  task report_and_stop();
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge pclk)
    if (++cyc == 3000)
    begin
      n_errors++;
      report_and_stop();
    end
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e)
    begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task pu(input logic [5:0] e, input logic [23:0] p);
    ev <= e;
    src_pulse <= p;
    tick(1);
    ev <= '0;
    src_pulse <= '0;
    tick(1);
  endtask
  task apb(input logic w, input logic [11:0] i, input logic [7:0] d,
    input logic [23:0] p = '0, input logic [1:0] lo = 2'b00);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, lo};
    pwdata <= {24'h00_0000, d};
    tick(1);
    penable <= 1'b1;
    src_pulse <= p;
    tick(1);
    src_pulse <= '0;
    while (!pready) tick(1);
    rd = prdata[7:0];
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    tick(1);
  endtask
  task serve(input logic [15:0] e);
    while (!cpu_ack) tick(1);
    tick(1);
    chk(tv, e);
  endtask
  task t_reset();
    apb(0, IDX_REQ0, 0);
    chk(rd, RST_REQ);
    apb(0, 12'h0fff, 0);
    chk({rd, er}, 9'h001);
    apb(0, IDX_REQ0, 0, '0, 2'b10);
    chk({rd, er}, 9'h001);
    chk(irq, 1'b0);
    $display("reset test done");
  endtask
  task t_poll();
    pu('0, 24'h00_0080);
    tick(3);
    chk(cpu_irq_req, 1'b0);
    apb(0, IDX_REQ0, 0);
    chk(rd, 8'h80);
    apb(1, IDX_REQ0, 8'h00, 24'h00_0001);
    apb(0, IDX_REQ0, 0);
    chk(rd, 8'h01);
    apb(1, IDX_REQ2, 8'h10);
    apb(0, IDX_REQ2, 0);
    chk(rd, 8'h10);
    $display("poll test done");
  endtask
  task t_prio();
    apb(1, IDX_PRIH0, 8'h01);
    apb(1, IDX_PRIL0, 8'h80);
    apb(1, IDX_PRIL2, 8'h10);
    pu('0, 24'h00_0080);
    wt <= 4'h5;
    apb(1, IDX_CTRL, 8'h80);
    serve(16'h0016);
    tick(4);
    chk(cpu_irq_req, 1'b0);
    apb(0, IDX_REQ0, 0);
    chk(rd, 8'h80);
    wt <= 4'h0;
    pu(6'h01, '0);
    serve(16'h0008);
    pu(6'h04, '0);
    serve(16'h002e);
    pu(6'h03, 24'h00_0080);
    tick(3);
    chk(cpu_irq_req, 1'b0);
    pu(6'h09, '0);
    tick(3);
    chk(cpu_irq_req, 1'b0);
    $display("priority test done");
  endtask
  task t_fixed();
    wdt_int_en <= 1'b1;
    pu(6'h20, '0);
    serve(VEC_WDT);
    pu(6'h10, '0);
    serve(VEC_TRAP);
    wdt_int_en <= 1'b0;
    pu(6'h20, '0);
    tick(3);
    chk(cpu_irq_req, 1'b0);
    $display("fixed source test done");
  endtask
  task t_event();
    pu('0, 24'h00_0080);
    apb(1, IDX_IMASK, 8'h02);
    chk(irq, 1'b1);
    apb(1, IDX_ISTAT, 8'h02);
    chk(irq, 1'b0);
    apb(1, IDX_IMASK, 8'h01);
    chk(irq, 1'b1);
    apb(1, IDX_ISTAT, 8'h01);
    chk(irq, 1'b0);
    $display("event test done");
  endtask
  initial
  begin
    tick(5);
    presetn <= 1'b1;
    tick(1);
    t_reset();
    t_poll();
    t_prio();
    t_fixed();
    t_event();
    report_and_stop();
  end
endmodule
